// ---- tb/lsd_checker_sva.sv ----
// Timing and result checks on the transfer sequencer.
// Assumes a bind to load_store_transfer_decode.
module lsd_checker (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                sys_rst,
  // Watched ports
  input wire logic [7:0]          memRdData,
  input wire lsd_pkg::mem_req_s   memReq,
  input wire lsd_pkg::core_regs_s coreRegs,
  input wire logic                instrDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fetch_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Opcode cycle follows reset or a finished instruction
  always_ff @(posedge ref_clk) fetch_r <= sys_rst || instrDone;
  a_imm_load_done: assert property (fetch_r && memRdData == 8'hC4 |=> instrDone)
    else $error("C4 length");
  a_load_nz_flags: assert property (fetch_r && memRdData == 8'hC4 |-> ##2 coreRegs.flagN == coreRegs.acc[7]
    && coreRegs.flagZ == (coreRegs.acc == 8'h00)) else $error("load flags");
  a_absy_load_time: assert property (fetch_r && memRdData == 8'hD5 |=> !instrDone [*3] ##1 instrDone)
    else $error("D5 length");
  a_ind_load_time: assert property (fetch_r && memRdData inside {8'hD6, 8'hD7}
    |=> !instrDone [*4] ##1 instrDone) else $error("D6 length");
  a_ind_store_time: assert property (fetch_r && memRdData inside {8'hF6, 8'hF7}
    |=> !instrDone [*5] ##1 instrDone) else $error("F7 length");
  a_xinc_step: assert property (fetch_r && memRdData inside {8'hDB, 8'hFB}
    |-> ##4 coreRegs.idxX == $past(coreRegs.idxX, 4) + 8'h01) else $error("X step");
  a_store_flag_keep: assert property (fetch_r && memRdData == 8'hE5
    |=> ($stable(coreRegs.flagN) && $stable(coreRegs.flagZ)) [*4]) else $error("store flags");
  a_sp_from_x: assert property (fetch_r && memRdData == 8'h8E
    |-> ##2 coreRegs.stackPtr == $past(coreRegs.idxX, 2)) else $error("8E copy");
  a_swap_acc_x: assert property (fetch_r && memRdData == 8'hEE |-> ##4
    coreRegs.acc == $past(coreRegs.idxX, 4) && coreRegs.idxX == $past(coreRegs.acc, 4)) else $error("EE swap");
  a_ldmem_length: assert property (fetch_r && memRdData == 8'hE4
    |-> ##5 memReq.addr == $past(memReq.addr, 5) + 16'h0003) else $error("E4 length");
  c_mem_swap: cover property (fetch_r && memRdData == 8'hBC);
  c_ind_store: cover property (fetch_r && memRdData == 8'hF7);
  c_auto_inc: cover property (fetch_r && memRdData == 8'hDB);
endmodule
bind load_store_transfer_decode lsd_checker lsdCheck (.ref_clk, .sys_rst, .memRdData, .memReq, .coreRegs, .instrDone);

// ---- tb/mem_model.sv ----
// Byte memory facing the sequencer.
// Assumes same-cycle reads and writes landing at the edge.
module mem_model (
  // Clock
  input wire logic              ref_clk,
  // Request and answer
  input wire lsd_pkg::mem_req_s memReq,
  output logic [7:0]            memRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] lastRd = 8'h00;
  // Each byte holds its low address byte, so data is predictable
  initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0];
  // Idle cycles show the last read byte inverted, never a stale byte
  assign memRdData = memReq.rdEn ? mem[memReq.addr] : ~lastRd;
  always @(posedge ref_clk) begin
    if (memReq.rdEn) lastRd <= mem[memReq.addr];
    if (memReq.wrEn) mem[memReq.addr] <= memReq.wrData;
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench of the transfer sequencer.
// Assumes mem_model as memory; direct page is 01xx, code sits in 00xx.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk = 1'b0;
  logic                sys_rst = 1'b1;
  logic [7:0]          memRdData;
  lsd_pkg::mem_req_s   memReq;
  lsd_pkg::core_regs_s coreRegs;
  logic                instrDone;
  logic [15:0]         pcExp = 16'h0000;
  logic [15:0]         progCnt;
  logic                illegalOp;
  // Opcode outside the transfer group
  localparam logic [7:0] FOREIGN_OP = 8'h88;
  int                  errors = 0;
  int                  comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  load_store_transfer_decode dut (.ref_clk, .sys_rst, .dirPageSel(1'b1), .memRdData, .memReq, .coreRegs,
    .progCnt, .instrDone, .illegalOp);
  mem_model ram (.ref_clk, .memReq, .memRdData);
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Runs one instruction from the fetch cycle; rg is {acc, X, Y}
  task automatic x(input logic [23:0] ins, input int len, input int cyc, input logic [23:0] rg, input logic [1:0] nz);
    int n;
    n = 1;
    chk(24'(memReq.addr), 24'(pcExp));
    chk(24'(progCnt), 24'(pcExp));
    for (int i = 0; i < 3; i++) ram.mem[pcExp + 16'(i)] = ins[23 - 8 * i -: 8];
    // Opcode lands at this edge; let the decode settle first
    #1;
    chk(24'(illegalOp), 24'(ins[23:16] == FOREIGN_OP));
    while (instrDone !== 1'b1 && n < 9) begin
      @(negedge ref_clk);
      n++;
    end
    chk(24'(n), 24'(cyc));
    @(negedge ref_clk);
    pcExp = pcExp + 16'(len);
    chk({coreRegs.acc, coreRegs.idxX, coreRegs.idxY}, rg);
    chk(24'({coreRegs.flagN, coreRegs.flagZ}), 24'(nz));
  endtask
  task automatic m(input logic [15:0] a, input logic [7:0] v);
    chk(24'(ram.mem[a]), 24'(v));
  endtask
  task automatic t_loads();
    x(24'hC48000, 2, 2, 24'h800000, 2'h2);
    x(24'hC50000, 2, 3, 24'h000000, 2'h1);
    x(24'h1E0500, 2, 2, 24'h000500, 2'h0);
    x(24'h3E9000, 2, 2, 24'h000590, 2'h2);
    x(24'hC63000, 2, 4, 24'h350590, 2'h0);
    x(24'hD53412, 3, 5, 24'hC40590, 2'h2);
    $display("loads done");
  endtask
  task automatic t_stores();
    x(24'hE5A000, 2, 4, 24'hC40590, 2'h2);
    x(24'hF75000, 2, 7, 24'hC40590, 2'h2);
    x(24'hED7000, 2, 5, 24'hC40590, 2'h2);
    x(24'hE477B0, 3, 5, 24'hC40590, 2'h2);
    x(24'hFB0000, 1, 4, 24'hC40690, 2'h2);
    m(16'h01A0, 8'hC4);
    m(16'h51E0, 8'hC4);
    m(16'h0100, 8'h05);
    m(16'h01B0, 8'h77);
    m(16'h0105, 8'hC4);
    $display("stores done");
  endtask
  task automatic t_moves();
    x(24'hEE0000, 1, 4, 24'h06C490, 2'h2);
    x(24'hD64000, 2, 6, 24'h04C490, 2'h0);
    x(24'hDB0000, 1, 4, 24'hC4C590, 2'h2);
    x(24'hE80000, 1, 2, 24'hC4C490, 2'h2);
    x(24'h8E0000, 1, 2, 24'hC4C490, 2'h2);
    x(24'h1E0000, 2, 2, 24'hC40090, 2'h1);
    x(24'hAE0000, 1, 2, 24'hC4C490, 2'h2);
    x(24'h3E0000, 2, 2, 24'hC4C400, 2'h1);
    x(24'hBF0000, 1, 2, 24'h00C400, 2'h1);
    x(24'hBCC000, 2, 5, 24'hC0C400, 2'h2);
    m(16'h01C0, 8'h00);
    $display("moves done");
  endtask
  // Y store, remaining copies, Y swap, indexed memory swap, indirect Y load, foreign opcode
  task automatic t_more();
    x(24'h9F0000, 1, 2, 24'hC0C4C0, 2'h2);
    x(24'hC80000, 1, 2, 24'hC4C4C0, 2'h2);
    x(24'hF92000, 2, 5, 24'hC4C4C0, 2'h2);
    x(24'hDE0000, 1, 4, 24'hC0C4C4, 2'h2);
    x(24'hAD1C00, 2, 6, 24'hE0C4C4, 2'h2);
    x(24'hD71000, 2, 6, 24'hD4C4C4, 2'h2);
    x(24'h880000, 1, 2, 24'hD4C4C4, 2'h2);
    m(16'h01E4, 8'hC0);
    m(16'h01E0, 8'hC0);
    $display("more moves done");
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    t_loads();
    t_stores();
    t_moves();
    t_more();
    complete_run();
  end
  initial begin
    #100000;
    errors++;
    complete_run();
  end
endmodule

// ---- verilog/load_store_transfer_decode.sv ----
// Load, store, copy and swap sequencer of an 8-bit core.
// Assumes a single-port byte memory that answers a read in the same cycle.
`include "lsd_consts.svh"

module load_store_transfer_decode (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  // Direct page select from the status word
  input  wire logic                dirPageSel,
  // Memory port
  input  wire logic [7:0]          memRdData,
  output lsd_pkg::mem_req_s        memReq,
  // Core state and events
  output lsd_pkg::core_regs_s      coreRegs,
  output logic [15:0]              progCnt,
  output logic                     instrDone,
  output logic                     illegalOp
);

  lsd_pkg::phase_e     phase_r;
  lsd_pkg::phase_e     phase_nxt;
  lsd_pkg::decode_s    dec;
  lsd_pkg::core_regs_s core_r;
  lsd_pkg::core_regs_s core_nxt;
  lsd_pkg::mem_req_s   req_r;
  lsd_pkg::mem_req_s   req_nxt;
  logic [2:0]          cyc_r;
  logic [15:0]         pc_r;
  logic [15:0]         pc_nxt;
  logic [7:0]          opcode_r;
  logic [7:0]          op1_r;
  logic [7:0]          op2_r;
  logic [7:0]          ptrLo_r;
  logic [7:0]          ptrHi_r;
  logic [7:0]          data_r;
  logic [7:0]          o1;
  logic [7:0]          o2;
  logic [7:0]          pL;
  logic [7:0]          pH;
  logic [7:0]          valNow;
  logic [7:0]          srcVal;
  logic [15:0]         ptrAddrLo;
  logic [15:0]         ptrAddrHi;
  logic [15:0]         effAddr;
  logic                isLast;
  logic                needsMem;
  logic                lastOperand;

  function automatic lsd_pkg::decode_s mk(input logic [1:0] l, input logic [2:0] c,
                                          input lsd_pkg::addr_mode_e m, input lsd_pkg::op_kind_e k,
                                          input lsd_pkg::reg_sel_e d, input lsd_pkg::reg_sel_e s,
                                          input logic xi, input logic nz);
    lsd_pkg::decode_s r;
    r = '{known: 1'b1, len: l, cycles: c, mode: m, kind: k, dst: d, src: s, xInc: xi, setsNz: nz};
    return r;
  endfunction

  function automatic lsd_pkg::decode_s decodeOp(input logic [7:0] op);
    lsd_pkg::decode_s d;
    d = mk(`LEN_1, `CYC_2, lsd_pkg::AM_IMPLIED, lsd_pkg::OP_NONE, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b0);
    d.known = 1'b0;
    case (op)
      `OPC_LD_ACC_IMM:  d = mk(`LEN_2, `CYC_2, lsd_pkg::AM_IMM,  lsd_pkg::OP_LOAD, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_LD_ACC_DIR:  d = mk(`LEN_2, `CYC_3, lsd_pkg::AM_DIR,  lsd_pkg::OP_LOAD, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_LD_ACC_DIRX: d = mk(`LEN_2, `CYC_4, lsd_pkg::AM_DIRX, lsd_pkg::OP_LOAD, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_LD_ACC_ABS:  d = mk(`LEN_3, `CYC_4, lsd_pkg::AM_ABS,  lsd_pkg::OP_LOAD, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_LD_ACC_ABSY: d = mk(`LEN_3, `CYC_5, lsd_pkg::AM_ABSY, lsd_pkg::OP_LOAD, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_LD_ACC_INDX: d = mk(`LEN_2, `CYC_6, lsd_pkg::AM_INDX, lsd_pkg::OP_LOAD, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_LD_ACC_INDY: d = mk(`LEN_2, `CYC_6, lsd_pkg::AM_INDY, lsd_pkg::OP_LOAD, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_LD_ACC_XIND: d = mk(`LEN_1, `CYC_3, lsd_pkg::AM_XIND, lsd_pkg::OP_LOAD, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_LD_ACC_XINC: d = mk(`LEN_1, `CYC_4, lsd_pkg::AM_XIND, lsd_pkg::OP_LOAD, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b1, 1'b1);
      `OPC_LD_MEM_IMM:  d = mk(`LEN_3, `CYC_5, lsd_pkg::AM_DIR, lsd_pkg::OP_LDMEM, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b0);
      `OPC_LD_X_IMM:    d = mk(`LEN_2, `CYC_2, lsd_pkg::AM_IMM,  lsd_pkg::OP_LOAD, lsd_pkg::R_X, lsd_pkg::R_X, 1'b0, 1'b1);
      `OPC_LD_X_DIR:    d = mk(`LEN_2, `CYC_3, lsd_pkg::AM_DIR,  lsd_pkg::OP_LOAD, lsd_pkg::R_X, lsd_pkg::R_X, 1'b0, 1'b1);
      `OPC_LD_X_DIRY:   d = mk(`LEN_2, `CYC_4, lsd_pkg::AM_DIRY, lsd_pkg::OP_LOAD, lsd_pkg::R_X, lsd_pkg::R_X, 1'b0, 1'b1);
      `OPC_LD_X_ABS:    d = mk(`LEN_3, `CYC_4, lsd_pkg::AM_ABS,  lsd_pkg::OP_LOAD, lsd_pkg::R_X, lsd_pkg::R_X, 1'b0, 1'b1);
      `OPC_LD_Y_IMM:    d = mk(`LEN_2, `CYC_2, lsd_pkg::AM_IMM,  lsd_pkg::OP_LOAD, lsd_pkg::R_Y, lsd_pkg::R_Y, 1'b0, 1'b1);
      `OPC_LD_Y_DIR:    d = mk(`LEN_2, `CYC_3, lsd_pkg::AM_DIR,  lsd_pkg::OP_LOAD, lsd_pkg::R_Y, lsd_pkg::R_Y, 1'b0, 1'b1);
      `OPC_LD_Y_DIRX:   d = mk(`LEN_2, `CYC_4, lsd_pkg::AM_DIRX, lsd_pkg::OP_LOAD, lsd_pkg::R_Y, lsd_pkg::R_Y, 1'b0, 1'b1);
      `OPC_LD_Y_ABS:    d = mk(`LEN_3, `CYC_4, lsd_pkg::AM_ABS,  lsd_pkg::OP_LOAD, lsd_pkg::R_Y, lsd_pkg::R_Y, 1'b0, 1'b1);
      `OPC_ST_ACC_DIR:  d = mk(`LEN_2, `CYC_4, lsd_pkg::AM_DIR,  lsd_pkg::OP_STORE, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b0);
      `OPC_ST_ACC_DIRX: d = mk(`LEN_2, `CYC_5, lsd_pkg::AM_DIRX, lsd_pkg::OP_STORE, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b0);
      `OPC_ST_ACC_ABS:  d = mk(`LEN_3, `CYC_5, lsd_pkg::AM_ABS,  lsd_pkg::OP_STORE, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b0);
      `OPC_ST_ACC_ABSY: d = mk(`LEN_3, `CYC_6, lsd_pkg::AM_ABSY, lsd_pkg::OP_STORE, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b0);
      `OPC_ST_ACC_INDX: d = mk(`LEN_2, `CYC_7, lsd_pkg::AM_INDX, lsd_pkg::OP_STORE, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b0);
      `OPC_ST_ACC_INDY: d = mk(`LEN_2, `CYC_7, lsd_pkg::AM_INDY, lsd_pkg::OP_STORE, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b0);
      `OPC_ST_ACC_XIND: d = mk(`LEN_1, `CYC_4, lsd_pkg::AM_XIND, lsd_pkg::OP_STORE, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b0);
      `OPC_ST_ACC_XINC: d = mk(`LEN_1, `CYC_4, lsd_pkg::AM_XIND, lsd_pkg::OP_STORE, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b1, 1'b0);
      `OPC_ST_X_DIR:    d = mk(`LEN_2, `CYC_4, lsd_pkg::AM_DIR,  lsd_pkg::OP_STORE, lsd_pkg::R_X, lsd_pkg::R_X, 1'b0, 1'b0);
      `OPC_ST_X_DIRY:   d = mk(`LEN_2, `CYC_5, lsd_pkg::AM_DIRY, lsd_pkg::OP_STORE, lsd_pkg::R_X, lsd_pkg::R_X, 1'b0, 1'b0);
      `OPC_ST_X_ABS:    d = mk(`LEN_3, `CYC_5, lsd_pkg::AM_ABS,  lsd_pkg::OP_STORE, lsd_pkg::R_X, lsd_pkg::R_X, 1'b0, 1'b0);
      `OPC_ST_Y_DIR:    d = mk(`LEN_2, `CYC_4, lsd_pkg::AM_DIR,  lsd_pkg::OP_STORE, lsd_pkg::R_Y, lsd_pkg::R_Y, 1'b0, 1'b0);
      `OPC_ST_Y_DIRX:   d = mk(`LEN_2, `CYC_5, lsd_pkg::AM_DIRX, lsd_pkg::OP_STORE, lsd_pkg::R_Y, lsd_pkg::R_Y, 1'b0, 1'b0);
      `OPC_ST_Y_ABS:    d = mk(`LEN_3, `CYC_5, lsd_pkg::AM_ABS,  lsd_pkg::OP_STORE, lsd_pkg::R_Y, lsd_pkg::R_Y, 1'b0, 1'b0);
      `OPC_CP_A_X:      d = mk(`LEN_1, `CYC_2, lsd_pkg::AM_IMPLIED, lsd_pkg::OP_COPY, lsd_pkg::R_X, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_CP_A_Y:      d = mk(`LEN_1, `CYC_2, lsd_pkg::AM_IMPLIED, lsd_pkg::OP_COPY, lsd_pkg::R_Y, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_CP_X_A:      d = mk(`LEN_1, `CYC_2, lsd_pkg::AM_IMPLIED, lsd_pkg::OP_COPY, lsd_pkg::R_ACC, lsd_pkg::R_X, 1'b0, 1'b1);
      `OPC_CP_Y_A:      d = mk(`LEN_1, `CYC_2, lsd_pkg::AM_IMPLIED, lsd_pkg::OP_COPY, lsd_pkg::R_ACC, lsd_pkg::R_Y, 1'b0, 1'b1);
      `OPC_CP_SP_X:     d = mk(`LEN_1, `CYC_2, lsd_pkg::AM_IMPLIED, lsd_pkg::OP_COPY, lsd_pkg::R_X, lsd_pkg::R_SP, 1'b0, 1'b1);
      `OPC_CP_X_SP:     d = mk(`LEN_1, `CYC_2, lsd_pkg::AM_IMPLIED, lsd_pkg::OP_COPY, lsd_pkg::R_SP, lsd_pkg::R_X, 1'b0, 1'b0);
      `OPC_SW_A_X:      d = mk(`LEN_1, `CYC_4, lsd_pkg::AM_IMPLIED, lsd_pkg::OP_SWAPREG, lsd_pkg::R_ACC, lsd_pkg::R_X, 1'b0, 1'b0);
      `OPC_SW_A_Y:      d = mk(`LEN_1, `CYC_4, lsd_pkg::AM_IMPLIED, lsd_pkg::OP_SWAPREG, lsd_pkg::R_ACC, lsd_pkg::R_Y, 1'b0, 1'b0);
      `OPC_SW_MEM_DIR:  d = mk(`LEN_2, `CYC_5, lsd_pkg::AM_DIR,  lsd_pkg::OP_SWAPMEM, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      `OPC_SW_MEM_DIRX: d = mk(`LEN_2, `CYC_6, lsd_pkg::AM_DIRX, lsd_pkg::OP_SWAPMEM, lsd_pkg::R_ACC, lsd_pkg::R_ACC, 1'b0, 1'b1);
      default: ;
    endcase
    return d;
  endfunction

  function automatic logic [7:0] getReg(input lsd_pkg::core_regs_s c, input lsd_pkg::reg_sel_e s);
    logic [7:0] v;
    case (s)
      lsd_pkg::R_X:  v = c.idxX;
      lsd_pkg::R_Y:  v = c.idxY;
      lsd_pkg::R_SP: v = c.stackPtr;
      default:       v = c.acc;
    endcase
    return v;
  endfunction

  function automatic lsd_pkg::core_regs_s setReg(input lsd_pkg::core_regs_s c, input lsd_pkg::reg_sel_e s,
                                                 input logic [7:0] v);
    lsd_pkg::core_regs_s r;
    r = c;
    case (s)
      lsd_pkg::R_X:  r.idxX = v;
      lsd_pkg::R_Y:  r.idxY = v;
      lsd_pkg::R_SP: r.stackPtr = v;
      default:       r.acc = v;
    endcase
    return r;
  endfunction

  // Opcode is decoded straight off the bus in the fetch cycle
  assign dec         = decodeOp((phase_r == lsd_pkg::PH_FETCH) ? memRdData : opcode_r);
  assign isLast      = cyc_r == (dec.cycles - `STEP_ONE);
  assign lastOperand = cyc_r >= ({1'b0, dec.len} - `STEP_ONE);
  assign needsMem    = (dec.mode != lsd_pkg::AM_IMM) &&
                       (dec.kind inside {lsd_pkg::OP_LOAD, lsd_pkg::OP_STORE, lsd_pkg::OP_LDMEM, lsd_pkg::OP_SWAPMEM});
  assign srcVal      = getReg(core_r, dec.src);

  // Bytes arriving this cycle are used at once to aim the next access
  assign o1 = (phase_r == lsd_pkg::PH_OPERAND && cyc_r == `STEP_OPND1) ? memRdData : op1_r;
  assign o2 = (phase_r == lsd_pkg::PH_OPERAND && cyc_r == `STEP_OPND2) ? memRdData : op2_r;
  assign pL = (phase_r == lsd_pkg::PH_PTR_LO) ? memRdData : ptrLo_r;
  assign pH = (phase_r == lsd_pkg::PH_PTR_HI) ? memRdData : ptrHi_r;
  assign valNow = (phase_r == lsd_pkg::PH_OPERAND || phase_r == lsd_pkg::PH_DATA) ? memRdData : data_r;

  // Immediate-to-memory carries its address in the last byte
  operand_addr_gen u_addr (
    .mode      (dec.mode),
    .dirPageSel(dirPageSel),
    .dirByte   ((dec.kind == lsd_pkg::OP_LDMEM) ? o2 : o1),
    .absHigh   (o2),
    .ptrValue  ({pH, pL}),
    .idxX      (core_r.idxX),
    .idxY      (core_r.idxY),
    .ptrAddrLo (ptrAddrLo),
    .ptrAddrHi (ptrAddrHi),
    .effAddr   (effAddr)
  );

  // Phase sequencing; padding cycles make up the full count
  always_comb begin
    phase_nxt = phase_r;
    if (isLast) begin
      phase_nxt = lsd_pkg::PH_FETCH;
    end else begin
      case (phase_r)
        lsd_pkg::PH_FETCH: begin
          if (dec.len != `LEN_1) phase_nxt = lsd_pkg::PH_OPERAND;
          else if (needsMem)     phase_nxt = lsd_pkg::PH_DATA;
          else                   phase_nxt = lsd_pkg::PH_WAIT;
        end
        lsd_pkg::PH_OPERAND: begin
          if (!lastOperand)                                                    phase_nxt = lsd_pkg::PH_OPERAND;
          else if (dec.mode == lsd_pkg::AM_INDX || dec.mode == lsd_pkg::AM_INDY) phase_nxt = lsd_pkg::PH_PTR_LO;
          else if (needsMem)                                                   phase_nxt = lsd_pkg::PH_DATA;
          else                                                                 phase_nxt = lsd_pkg::PH_WAIT;
        end
        lsd_pkg::PH_PTR_LO: phase_nxt = lsd_pkg::PH_PTR_HI;
        lsd_pkg::PH_PTR_HI: phase_nxt = lsd_pkg::PH_DATA;
        lsd_pkg::PH_DATA:   phase_nxt = (dec.kind == lsd_pkg::OP_SWAPMEM) ? lsd_pkg::PH_SWAP_WR : lsd_pkg::PH_WAIT;
        lsd_pkg::PH_SWAP_WR: phase_nxt = lsd_pkg::PH_WAIT;
        lsd_pkg::PH_WAIT:   phase_nxt = lsd_pkg::PH_WAIT;
        default:            phase_nxt = lsd_pkg::PH_FETCH;
      endcase
    end
  end
  assign pc_nxt = (phase_r == lsd_pkg::PH_FETCH || phase_r == lsd_pkg::PH_OPERAND) ? pc_r + 16'h0001 : pc_r;

  // Memory request for the next cycle, registered
  always_comb begin
    req_nxt = '{addr: pc_nxt, rdEn: 1'b0, wrEn: 1'b0, wrData: `BYTE_ZERO};
    case (phase_nxt)
      lsd_pkg::PH_FETCH, lsd_pkg::PH_OPERAND: req_nxt.rdEn = 1'b1;
      lsd_pkg::PH_PTR_LO: begin
        req_nxt.addr = ptrAddrLo;
        req_nxt.rdEn = 1'b1;
      end
      lsd_pkg::PH_PTR_HI: begin
        req_nxt.addr = ptrAddrHi;
        req_nxt.rdEn = 1'b1;
      end
      lsd_pkg::PH_DATA: begin
        req_nxt.addr = effAddr;
        req_nxt.rdEn = dec.kind inside {lsd_pkg::OP_LOAD, lsd_pkg::OP_SWAPMEM};
        req_nxt.wrEn   = dec.kind inside {lsd_pkg::OP_STORE, lsd_pkg::OP_LDMEM};
        req_nxt.wrData = (dec.kind == lsd_pkg::OP_LDMEM) ? o1 : srcVal;
      end
      lsd_pkg::PH_SWAP_WR: begin
        // old acc goes back to memory
        req_nxt.addr   = req_r.addr;
        req_nxt.wrEn   = 1'b1;
        req_nxt.wrData = core_r.acc;
      end
      default: ;
    endcase
  end

  // Register updates land on the final cycle only
  always_comb begin
    core_nxt = core_r;
    if (isLast) begin
      case (dec.kind)
        lsd_pkg::OP_LOAD, lsd_pkg::OP_SWAPMEM: core_nxt = setReg(core_r, dec.dst, valNow);
        lsd_pkg::OP_COPY:                      core_nxt = setReg(core_r, dec.dst, srcVal);
        lsd_pkg::OP_SWAPREG: begin
          core_nxt     = setReg(core_r, dec.src, core_r.acc);
          core_nxt.acc = srcVal;
        end
        default: ;
      endcase
      if (dec.setsNz) begin
        core_nxt.flagN = (getReg(core_nxt, dec.dst) & `SIGN_BIT_MASK) != `BYTE_ZERO;
        core_nxt.flagZ = getReg(core_nxt, dec.dst) == `BYTE_ZERO;
      end
      if (dec.xInc) core_nxt.idxX = core_r.idxX + `BYTE_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_r <= lsd_pkg::PH_FETCH;
      cyc_r   <= 3'h0;
    end else begin
      phase_r <= phase_nxt;
      cyc_r   <= isLast ? 3'h0 : cyc_r + `STEP_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pc_r  <= `PC_RESET;
      req_r <= '{addr: `PC_RESET, rdEn: 1'b1, wrEn: 1'b0, wrData: `BYTE_ZERO};
    end else begin
      pc_r  <= pc_nxt;
      req_r <= req_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      opcode_r <= `BYTE_ZERO;
      op1_r    <= `BYTE_ZERO;
      op2_r    <= `BYTE_ZERO;
      ptrLo_r  <= `BYTE_ZERO;
      ptrHi_r  <= `BYTE_ZERO;
      data_r   <= `BYTE_ZERO;
    end else begin
      if (phase_r == lsd_pkg::PH_FETCH) opcode_r <= memRdData;
      op1_r   <= o1;
      op2_r   <= o2;
      ptrLo_r <= pL;
      ptrHi_r <= pH;
      data_r  <= valNow;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_r <= '{acc: `BYTE_ZERO, idxX: `BYTE_ZERO, idxY: `BYTE_ZERO, stackPtr: `SP_RESET,
                  flagN: 1'b0, flagZ: 1'b0};
    end else begin
      core_r <= core_nxt;
    end
  end

  assign memReq    = req_r;
  assign coreRegs  = core_r;
  assign progCnt   = pc_r;
  assign instrDone = isLast && !sys_rst;
  assign illegalOp = (phase_r == lsd_pkg::PH_FETCH) && !dec.known && !sys_rst;
endmodule

// ---- verilog/lsd_consts.svh ----
// Named constants for the load, store and transfer sequencer.
// Assumes inclusion by bare name from files under verilog/.
`ifndef LSD_CONSTS_SVH
`define LSD_CONSTS_SVH

// Opcodes: loads
`define OPC_LD_ACC_IMM   8'hC4
`define OPC_LD_ACC_DIR   8'hC5
`define OPC_LD_ACC_DIRX  8'hC6
`define OPC_LD_ACC_ABS   8'hC7
`define OPC_LD_ACC_ABSY  8'hD5
`define OPC_LD_ACC_INDX  8'hD6
`define OPC_LD_ACC_INDY  8'hD7
`define OPC_LD_ACC_XIND  8'hD4
`define OPC_LD_ACC_XINC  8'hDB
`define OPC_LD_MEM_IMM   8'hE4
`define OPC_LD_X_IMM     8'h1E
`define OPC_LD_X_DIR     8'hCC
`define OPC_LD_X_DIRY    8'hCD
`define OPC_LD_X_ABS     8'hDC
`define OPC_LD_Y_IMM     8'h3E
`define OPC_LD_Y_DIR     8'hC9
`define OPC_LD_Y_DIRX    8'hD9
`define OPC_LD_Y_ABS     8'hD8
// Opcodes: stores
`define OPC_ST_ACC_DIR   8'hE5
`define OPC_ST_ACC_DIRX  8'hE6
`define OPC_ST_ACC_ABS   8'hE7
`define OPC_ST_ACC_ABSY  8'hF5
`define OPC_ST_ACC_INDX  8'hF6
`define OPC_ST_ACC_INDY  8'hF7
`define OPC_ST_ACC_XIND  8'hF4
`define OPC_ST_ACC_XINC  8'hFB
`define OPC_ST_X_DIR     8'hEC
`define OPC_ST_X_DIRY    8'hED
`define OPC_ST_X_ABS     8'hFC
`define OPC_ST_Y_DIR     8'hE9
`define OPC_ST_Y_DIRX    8'hF9
`define OPC_ST_Y_ABS     8'hF8
// Opcodes: copies and swaps
`define OPC_CP_A_X       8'hE8
`define OPC_CP_A_Y       8'h9F
`define OPC_CP_SP_X      8'hAE
`define OPC_CP_X_A       8'hC8
`define OPC_CP_X_SP      8'h8E
`define OPC_CP_Y_A       8'hBF
`define OPC_SW_A_X       8'hEE
`define OPC_SW_A_Y       8'hDE
`define OPC_SW_MEM_DIR   8'hBC
`define OPC_SW_MEM_DIRX  8'hAD

// Instruction lengths and cycle counts
`define LEN_1            2'h1
`define LEN_2            2'h2
`define LEN_3            2'h3
`define CYC_2            3'h2
`define CYC_3            3'h3
`define CYC_4            3'h4
`define CYC_5            3'h5
`define CYC_6            3'h6
`define CYC_7            3'h7

// Sequencing and reset values
`define STEP_ONE         3'h1
`define STEP_OPND1       3'h1
`define STEP_OPND2       3'h2
`define PC_RESET         16'h0000
`define SP_RESET         8'hFF
`define BYTE_ZERO        8'h00
`define BYTE_ONE         8'h01
`define SIGN_BIT_MASK    8'h80
`define PAGE_HIGH_ZERO   7'h00

`endif

// ---- verilog/lsd_pkg.sv ----
// Types shared by the load, store and transfer sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package lsd_pkg;

  typedef enum logic [3:0] {
    AM_IMPLIED, AM_IMM, AM_DIR, AM_DIRX, AM_DIRY,
    AM_ABS, AM_ABSY, AM_INDX, AM_INDY, AM_XIND
  } addr_mode_e;

  typedef enum logic [2:0] {
    OP_NONE, OP_LOAD, OP_STORE, OP_LDMEM, OP_COPY, OP_SWAPREG, OP_SWAPMEM
  } op_kind_e;

  typedef enum logic [1:0] {R_ACC, R_X, R_Y, R_SP} reg_sel_e;

  typedef enum {PH_FETCH, PH_OPERAND, PH_PTR_LO, PH_PTR_HI, PH_DATA, PH_SWAP_WR, PH_WAIT} phase_e;

  typedef struct packed {
    logic       known;
    logic [1:0] len;
    logic [2:0] cycles;
    addr_mode_e mode;
    op_kind_e   kind;
    reg_sel_e   dst;
    reg_sel_e   src;
    logic       xInc;
    logic       setsNz;
  } decode_s;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] idxX;
    logic [7:0] idxY;
    logic [7:0] stackPtr;
    logic       flagN;
    logic       flagZ;
  } core_regs_s;

  typedef struct packed {
    logic [15:0] addr;
    logic        rdEn;
    logic        wrEn;
    logic [7:0]  wrData;
  } mem_req_s;

endpackage

// ---- verilog/operand_addr_gen.sv ----
// Operand address generator: pointer and effective addresses per mode.
// Assumes operand bytes and pointer are already resolved by the caller.
`include "lsd_consts.svh"

module operand_addr_gen (
  // Mode and page
  input  wire lsd_pkg::addr_mode_e mode,
  input  wire logic                dirPageSel,
  // Operand bytes and index registers
  input  wire logic [7:0]          dirByte,
  input  wire logic [7:0]          absHigh,
  input  wire logic [15:0]         ptrValue,
  input  wire logic [7:0]          idxX,
  input  wire logic [7:0]          idxY,
  // Addresses
  output logic      [15:0]         ptrAddrLo,
  output logic      [15:0]         ptrAddrHi,
  output logic      [15:0]         effAddr
);

  logic [7:0] page;
  logic [7:0] ptrOff;

  assign page = {`PAGE_HIGH_ZERO, dirPageSel};
  // Indexed pointer stays inside the page, as does its high byte
  assign ptrOff    = (mode == lsd_pkg::AM_INDX) ? dirByte + idxX : dirByte;
  assign ptrAddrLo = {page, ptrOff};
  assign ptrAddrHi = {page, ptrOff + `BYTE_ONE};

  always_comb begin
    case (mode)
      lsd_pkg::AM_DIR:  effAddr = {page, dirByte};
      lsd_pkg::AM_DIRX: effAddr = {page, dirByte + idxX};
      lsd_pkg::AM_DIRY: effAddr = {page, dirByte + idxY};
      lsd_pkg::AM_ABS:  effAddr = {absHigh, dirByte};
      lsd_pkg::AM_ABSY: effAddr = {absHigh, dirByte} + {`BYTE_ZERO, idxY};
      lsd_pkg::AM_INDX: effAddr = ptrValue;
      lsd_pkg::AM_INDY: effAddr = ptrValue + {`BYTE_ZERO, idxY};
      lsd_pkg::AM_XIND: effAddr = {page, idxX};
      default:          effAddr = {page, dirByte};
    endcase
  end

endmodule
